// [bench/media_engine_model.sv]
// media engine stand-in: runs a fixed span after each start pulse taken while idle
// assumes start is a one-cycle pulse on the device clock
`timescale 1ns/1ps
module media_engine_model #(
  parameter int SPAN = 40
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // engine control
  input  wire logic        start,
  input  wire logic        ok_cfg,
  output logic             op_end,
  output logic             op_ok,
  output logic [15:0]      op_progress
);
  int          cnt_q;
  logic [15:0] pat_q;
  // outside an operation the numerator is junk that keeps moving
  assign op_progress = (cnt_q != 0) ? 16'h4000 : pat_q;
  always_ff @(posedge clock) begin
    pat_q  <= srst ? 16'h0000 : pat_q + 16'h1357;
    op_end <= !srst && cnt_q == 1;
    op_ok  <= !srst && cnt_q == 1 && ok_cfg;
    if (srst) cnt_q <= 0;
    else if (cnt_q == 0) cnt_q <= start ? SPAN : 0;
    else cnt_q <= cnt_q - 1;
  end
endmodule

// [bench/sanitize_checker.sv]
// port checker for the sanitize freeze-lock block
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module sanitize_checker (
  // clock and reset
  input wire logic                    clock,
  input wire logic                    srst,
  input wire logic                    ce,
  // command and answer
  input wire logic                    cmd_valid,
  input wire sanitize_pkg::taskfile_s cmd,
  input wire logic                    ans_valid_q,
  input wire sanitize_pkg::answer_s   ans_q,
  input wire logic [15:0]             op_progress,
  input wire logic                    op_start_q,
  // stored completed-ok bit
  input wire logic                    nv_ok_in,
  input wire logic                    nv_ok_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic take;
  logic seen_q;
  logic ok_ans;
  assign take = ce && cmd_valid && cmd.opcode == sanitize_pkg::OPC_SANITIZE;
  assign ok_ans = ans_valid_q && !ans_q.status[0];
  always_ff @(posedge clock) begin
    if (srst) seen_q <= 1'b0;
    else if (ans_valid_q && ans_q.count[13]) seen_q <= 1'b1;
  end
  chk_answer_latency: assert property (!$past(srst) |-> ans_valid_q == $past(take))
    else $error("answer not one cycle after command");
  chk_err_abort_pair: assert property (ans_valid_q |-> ans_q.status[0] == ans_q.error[2])
    else $error("error bit and abort bit differ");
  chk_status_fixed: assert property (ans_valid_q |-> (ans_q.status & 8'hF4) == 8'h50)
    else $error("busy, fault, corrected or ready wrong");
  chk_idle_progress: assert property (ok_ans && !ans_q.count[14]
    |-> {ans_q.cyl_low, ans_q.sect_num} == 16'hFFFF)
    else $error("idle progress not all ones");
  chk_active_progress: assert property (ok_ans && ans_q.count[14]
    |-> {ans_q.cyl_low, ans_q.sect_num} == $past(op_progress))
    else $error("progress bytes wrong");
  chk_frozen_reason: assert property (ans_valid_q && ans_q.count[13]
    && $past(cmd.feature) == sanitize_pkg::FEAT_OVERWR
    |-> ans_q.status[0] && ans_q.sect_num == sanitize_pkg::RSN_FROZEN)
    else $error("frozen overwrite not refused");
  // a start pulse must belong to an overwrite taken outside frozen and active
  chk_start_origin: assert property (op_start_q |-> ans_valid_q
    && $past(cmd.feature) == sanitize_pkg::FEAT_OVERWR && !ans_q.count[13] && !ans_q.count[14])
    else $error("engine started without accepted overwrite");
  chk_start_given: assert property (ans_valid_q && !ans_q.error[2]
    && $past(cmd.feature) == sanitize_pkg::FEAT_OVERWR |-> op_start_q)
    else $error("accepted overwrite did not start engine");
  chk_abort_sticky: assert property (seen_q && ans_valid_q |-> ans_q.error[2])
    else $error("abort flag lost after freeze");
  chk_nv_restore: assert property ($fell(srst) |-> ##2 nv_ok_q == $past(nv_ok_in, 2))
    else $error("stored ok bit not restored");
  cover property (ans_valid_q && ans_q.count[13]);
  cover property (ans_valid_q && ans_q.count[14]);
  cover property (ans_valid_q && ans_q.sect_num == sanitize_pkg::RSN_UNSAN);
endmodule
bind sanitize_freeze_lock_status sanitize_checker chk_u (
  .clock(clock), .srst(srst), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
  .ans_valid_q(ans_valid_q), .ans_q(ans_q), .op_progress(op_progress),
  .op_start_q(op_start_q),
  .nv_ok_in(nv_ok_in), .nv_ok_q(nv_ok_q));

// [bench/tb_sanitize_freeze_lock_status.sv]
// self-checking bench for the sanitize freeze-lock block
// assumes the media engine model and a 200 MHz clock
`timescale 1ns/1ps
module tb_sanitize_freeze_lock_status;
  typedef struct packed {
    logic [15:0] f, c;
    logic [47:0] l, e, m;
  } row_s;
  localparam logic [47:0] MA = 48'hFFFFFFFFFFFF;
  localparam logic [47:0] MS = 48'hFFFF00000000;
  localparam logic [47:0] MR = 48'hFFFF0000FF00;
  localparam logic [47:0] MC = 48'hFFFFFFFF0000;
  localparam logic [47:0] KEY = {16'h0000, sanitize_pkg::FREEZE_KEY};
  logic clock = 1'b0, srst = 1'b1, cmd_valid = 1'b0, ok_cfg = 1'b0, nv_ok_in = 1'b0;
  logic ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  wstrb = 4'hF;
  logic        ans_valid_q, op_start_q, op_end, op_ok, nv_ok_q, irq_q;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] op_progress;
  sanitize_pkg::taskfile_s cmd = '0;
  sanitize_pkg::answer_s   ans_q, got;
  int          errors = 0, n_checks = 0;
  row_s rows [6] = '{
    '{16'h0000, 16'h0000, 48'h0, 48'h50000000FFFF, MA},
    '{16'h0011, 16'h0000, 48'h0, 48'h510400000200, MR},
    '{16'h0020, 16'h0000, 48'h0, 48'h510400000000, MR},
    '{16'h0014, 16'h0000, 48'h0, 48'h500000000000, MS},
    '{16'h0000, 16'h0000, 48'h0, 48'h500040000040, MA},
    '{16'h0014, 16'h0010, 48'h0, 48'h510400000000, MR}};
  sanitize_freeze_lock_status dut_u (
    .clock(clock), .srst(srst), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
    .ans_valid_q(ans_valid_q), .ans_q(ans_q), .op_start_q(op_start_q), .op_end(op_end),
    .op_ok(op_ok), .op_progress(op_progress), .nv_ok_in(nv_ok_in), .nv_ok_q(nv_ok_q),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_q(irq_q));
  media_engine_model eng_u (.clock(clock), .srst(srst), .start(op_start_q), .ok_cfg(ok_cfg),
    .op_end(op_end), .op_ok(op_ok), .op_progress(op_progress));
  // stand-in store only ever learns a one, enough for this sequence
  always @(posedge clock) if (nv_ok_q === 1'b1) nv_ok_in <= 1'b1;
  task automatic fail(input string s);
    errors++;
    $display("mismatch at %0t: %s", $time, s);
  endtask
  task automatic tst(input logic b, input string s);
    n_checks++;
    if (b !== 1'b1) fail(s);
  endtask
  task automatic sc(input logic [15:0] f, c, input logic [47:0] l, e, m);
    cmd <= '{sanitize_pkg::OPC_SANITIZE, f, c, l};
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
    #1;
    got = ans_q;
    tst(ans_valid_q, "no answer");
    tst((got & m) === (e & m), "answer fields");
    @(posedge clock);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_end();
    int i;
    for (i = 0; i < 200 && op_end !== 1'b1; i++) @(posedge clock);
    tst(i < 200, "no operation end");
    repeat (2) @(posedge clock);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    forever #2.5 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    fail("watchdog");
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    foreach (rows[i]) begin
      sc(rows[i].f, rows[i].c, rows[i].l, rows[i].e, rows[i].m);
      repeat (2) @(posedge clock);
    end
    $display("test table done");
    wait_end();
    sc(16'h0000, 16'h0000, 48'h0, 48'h50000000FFFF, MA);
    sc(16'h0014, 16'h0010, 48'h0, 48'h510400000100, MR);
    sc(16'h0014, 16'h0010, 48'h0, 48'h510400000100, MR);
    sc(16'h0000, 16'h0001, 48'h0, 48'h510400000000, MS);
    axw(sanitize_pkg::REG_CTRL, 32'h1);
    ok_cfg <= 1'b1;
    sc(16'h0014, 16'h0010, 48'h0, 48'h500000000000, MS);
    wait_end();
    sc(16'h0000, 16'h0000, 48'h0, 48'h50008000FFFF, MA);
    tst(nv_ok_q, "ok bit not kept");
    $display("test failed state done");
    sc(16'h0020, 16'h0000, KEY, 48'h500000000000, MS);
    sc(16'h0000, 16'h0000, 48'h0, 48'h5104A0000000, MC);
    tst(irq_q === 1'b0, "masked irq raised");
    axr(sanitize_pkg::REG_IRQ_ST);
    axr(sanitize_pkg::REG_STATE);
    tst(rd === 32'h00000062, "state register wrong");
    axr(sanitize_pkg::REG_PROG);
    tst(rd === 32'h0000FFFF, "progress register wrong");
    axw(sanitize_pkg::REG_IRQ_MSK, 32'h2);
    sc(16'h0014, 16'h0010, 48'h0, 48'h510400000300, MR);
    repeat (2) @(posedge clock);
    tst(irq_q === 1'b1, "irq missing");
    axr(sanitize_pkg::REG_IRQ_ST);
    tst(rd[1] === 1'b1, "abort event missing");
    repeat (2) @(posedge clock);
    tst(irq_q === 1'b0, "irq not cleared");
    // a command offered while the enable is low must not be taken
    ce <= 1'b0;
    cmd <= '{sanitize_pkg::OPC_SANITIZE, 16'h0000, 16'h0000, 48'h0};
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
    ce <= 1'b1;
    #1;
    tst(ans_valid_q === 1'b0, "command taken with enable low");
    @(posedge clock);
    axr(8'h20);
    tst(rs === sanitize_pkg::RESP_SLVERR, "unmapped read accepted");
    axw(sanitize_pkg::REG_STATE, 32'h0);
    tst(rs === sanitize_pkg::RESP_SLVERR, "read-only write accepted");
    $display("test frozen done");
    srst <= 1'b1;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    sc(16'h0000, 16'h0000, 48'h0, 48'h50008000FFFF, MA);
    $display("test reset done");
    complete_run();
  end
endmodule

// [src/sanitize_freeze_lock_status.sv]
// sanitize state machine, freeze-lock, status word and axi4-lite registers
// assumes taskfile commands and media engine signals on the same clock
//
// Operation
// - freeze-lock command enters frozen state
// - frozen aborts all but status query
// - only power-on or hardware reset unfreezes
// - count bit 15 reports completed without error
// - completed-ok bit survives power-on reset
// - count bit 14 shows operation in progress
// - count bit 13 shows frozen state
// - 16-bit progress in cylinder low, sector number
// - progress reads FFFFh when not active
// - abort flag once freeze-lock has succeeded
// - failed, mode zero, overwrite mode one aborts
// - error reason code in sector number
// - status query accepted in every state; the code aborts a clear-failed query after a mode-zero failure
// - failed mode-zero aborts mode-one requests until idle
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module sanitize_freeze_lock_status (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    srst,
  input  wire logic                    ce,
  // taskfile command in, answer out
  input  wire logic                    cmd_valid,
  input  wire sanitize_pkg::taskfile_s cmd,
  output logic                         ans_valid_q,
  output sanitize_pkg::answer_s        ans_q,
  // media sanitize engine
  output logic                         op_start_q,
  input  wire logic                    op_end,
  input  wire logic                    op_ok,
  input  wire logic [15:0]             op_progress,
  // nonvolatile completed-ok bit
  input  wire logic                    nv_ok_in,
  output logic                         nv_ok_q,
  // axi4-lite slave
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // interrupt
  output logic                         irq_q
);

  sanitize_pkg::san_state_e state_q;
  sanitize_pkg::san_state_e state_d;
  logic                     fail_mode_q;
  logic                     freeze_done_q;
  logic                     nv_load_q;
  logic [15:0]              prog_q;
  logic [sanitize_pkg::EV_W-1:0] ev_st_q;
  logic [sanitize_pkg::EV_W-1:0] ev_msk_q;
  logic [sanitize_pkg::EV_W-1:0] ev_set;
  logic [7:0]               aw_addr_q;
  logic                     aw_have_q;
  logic [31:0]              w_data_q;
  logic                     w_have_q;
  logic                     hw_rst;
  logic                     do_wr;
  logic                     rd_irq;
  logic                     is_cmd;
  logic                     abort;
  logic                     start;
  logic [7:0]               reason;
  logic                     mode1;
  logic                     key_ok;

  function automatic logic [15:0] progress_of(input sanitize_pkg::san_state_e s,
                                              input logic [15:0] p);
    progress_of = (s == sanitize_pkg::SAN_ACTIVE) ? p : sanitize_pkg::PROG_NONE;
  endfunction

  // command decode; the host keeps the opcode and feature layout
  assign is_cmd = cmd_valid && (cmd.opcode == sanitize_pkg::OPC_SANITIZE);
  assign mode1  = cmd.count[sanitize_pkg::FAIL_MODE_BIT];
  assign key_ok = (cmd.lba[31:0] == sanitize_pkg::FREEZE_KEY);

  always_comb begin
    state_d = state_q;
    abort   = 1'b0;
    start   = 1'b0;
    reason  = sanitize_pkg::RSN_NONE;
    if (hw_rst) begin
      state_d = sanitize_pkg::SAN_IDLE;
    end else if (op_end && state_q == sanitize_pkg::SAN_ACTIVE) begin
      state_d = op_ok ? sanitize_pkg::SAN_OK : sanitize_pkg::SAN_FAILED;
    end
    if (is_cmd) begin
      if (cmd.feature == sanitize_pkg::FEAT_STATUS) begin
        // status query runs in every state
        if (cmd.count[sanitize_pkg::CLR_FAIL_BIT] &&
            state_q == sanitize_pkg::SAN_FAILED) begin
          if (fail_mode_q) begin
            state_d = sanitize_pkg::SAN_IDLE;
          end else begin
            abort = 1'b1;
          end
        end
      end else if (state_q == sanitize_pkg::SAN_FROZEN) begin
        abort  = 1'b1;
        reason = sanitize_pkg::RSN_FROZEN;
      end else if (cmd.feature == sanitize_pkg::FEAT_FREEZE) begin
        if (!key_ok || state_q == sanitize_pkg::SAN_ACTIVE) begin
          abort = 1'b1;
        end else begin
          state_d = sanitize_pkg::SAN_FROZEN;
        end
      end else if (cmd.feature == sanitize_pkg::FEAT_OVERWR) begin
        if (state_q == sanitize_pkg::SAN_ACTIVE) begin
          abort = 1'b1;
        end else if (state_q == sanitize_pkg::SAN_FAILED && !fail_mode_q && mode1) begin
          abort  = 1'b1;
          reason = sanitize_pkg::RSN_UNSAN;
        end else begin
          start   = 1'b1;
          state_d = sanitize_pkg::SAN_ACTIVE;
        end
      end else begin
        abort  = 1'b1;
        reason = sanitize_pkg::RSN_BADFEAT;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q     <= sanitize_pkg::SAN_IDLE;
      fail_mode_q <= 1'b0;
      op_start_q  <= 1'b0;
    end else if (ce) begin
      state_q    <= state_d;
      op_start_q <= start;
      if (start) begin
        fail_mode_q <= mode1;
      end
    end
  end

  // cleared by power-on only; hardware reset keeps it
  always_ff @(posedge clock) begin
    if (srst) begin
      freeze_done_q <= 1'b0;
    end else if (ce && is_cmd && state_d == sanitize_pkg::SAN_FROZEN &&
                 state_q != sanitize_pkg::SAN_FROZEN) begin
      freeze_done_q <= 1'b1;
    end
  end

  // completed-ok bit held at zero in reset, reloaded from storage on the first enabled cycle after it
  always_ff @(posedge clock) begin
    if (srst) begin
      nv_load_q <= 1'b1;
      nv_ok_q   <= 1'b0;
    end else if (ce) begin
      nv_load_q <= 1'b0;
      if (nv_load_q) begin
        nv_ok_q <= nv_ok_in;
      end else if (start) begin
        nv_ok_q <= 1'b0;
      end else if (op_end && state_q == sanitize_pkg::SAN_ACTIVE) begin
        nv_ok_q <= op_ok;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prog_q <= sanitize_pkg::PROG_NONE;
    end else if (ce) begin
      prog_q <= progress_of(state_d, op_progress);
    end
  end

  // answer, one cycle after the command
  always_ff @(posedge clock) begin
    if (srst) begin
      ans_valid_q <= 1'b0;
      ans_q       <= '0;
    end else if (ce) begin
      ans_valid_q <= is_cmd;
      if (is_cmd) begin
        ans_q <= '0;
        ans_q.status[sanitize_pkg::ST_RDY_BIT]  <= 1'b1;
        ans_q.status[sanitize_pkg::ST_DSC_BIT]  <= 1'b1;
        ans_q.status[sanitize_pkg::ST_ERR_BIT]  <= abort || freeze_done_q;
        ans_q.error[sanitize_pkg::ER_ABT_BIT]   <= abort || freeze_done_q;
        ans_q.count[sanitize_pkg::CNT_OK_BIT]   <= nv_ok_q;
        ans_q.count[sanitize_pkg::CNT_ACT_BIT]  <=
          (state_q == sanitize_pkg::SAN_ACTIVE);
        ans_q.count[sanitize_pkg::CNT_FRZ_BIT]  <=
          (state_q == sanitize_pkg::SAN_FROZEN);
        {ans_q.cyl_low, ans_q.sect_num} <= progress_of(state_q, op_progress);
        if (abort) begin
          ans_q.sect_num <= reason;
        end
      end
    end
  end

  // axi4-lite write: address and data taken in either order
  assign do_wr  = aw_have_q && w_have_q && !s_axi_bvalid;
  assign hw_rst = do_wr && (aw_addr_q == sanitize_pkg::REG_CTRL) && w_data_q[sanitize_pkg::CTRL_HWRST];

  always_ff @(posedge clock) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sanitize_pkg::RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h00000000;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        // byte lane 0 holds every writable bit
        w_data_q     <= s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bresp  <= (aw_addr_q == sanitize_pkg::REG_CTRL ||
                         aw_addr_q == sanitize_pkg::REG_IRQ_MSK) ?
                        sanitize_pkg::RESP_OKAY : sanitize_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ev_msk_q <= '0;
    end else if (ce && do_wr && aw_addr_q == sanitize_pkg::REG_IRQ_MSK) begin
      ev_msk_q <= w_data_q[sanitize_pkg::EV_W-1:0];
    end
  end

  // axi4-lite read, one register a time
  assign rd_irq = s_axi_arvalid && s_axi_arready && (s_axi_araddr == sanitize_pkg::REG_IRQ_ST);

  always_ff @(posedge clock) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= sanitize_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= sanitize_pkg::RESP_OKAY;
        s_axi_rdata   <= 32'h00000000;
        unique case (s_axi_araddr)
          sanitize_pkg::REG_CTRL: s_axi_rdata <= 32'h00000000;
          sanitize_pkg::REG_STATE: s_axi_rdata <= {25'h0, freeze_done_q, nv_ok_q, state_q};
          sanitize_pkg::REG_PROG: s_axi_rdata <= {16'h0, prog_q};
          sanitize_pkg::REG_IRQ_ST: s_axi_rdata <= {28'h0, ev_st_q};
          sanitize_pkg::REG_IRQ_MSK: s_axi_rdata <= {28'h0, ev_msk_q};
          default: s_axi_rresp <= sanitize_pkg::RESP_SLVERR;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // sticky events; a new event beats the read that clears
  always_comb begin
    ev_set = '0;
    ev_set[sanitize_pkg::EV_DONE]   = is_cmd && !abort;
    ev_set[sanitize_pkg::EV_ABORT]  = is_cmd && abort;
    ev_set[sanitize_pkg::EV_OPEND]  = op_end && state_q == sanitize_pkg::SAN_ACTIVE;
    ev_set[sanitize_pkg::EV_FROZEN] = state_d == sanitize_pkg::SAN_FROZEN &&
                                      state_q != sanitize_pkg::SAN_FROZEN;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ev_st_q <= '0;
      irq_q   <= 1'b0;
    end else if (ce) begin
      ev_st_q <= (rd_irq ? '0 : ev_st_q) | ev_set;
      irq_q   <= |(((rd_irq ? '0 : ev_st_q) | ev_set) & ev_msk_q);
    end
  end

endmodule

// [src/sanitize_pkg.sv]
// constants and carriers for the sanitize freeze-lock command logic
// assumes one 200 MHz clock shared by the taskfile decoder and the bus
package sanitize_pkg;

  // taskfile codes
  localparam logic [7:0]  OPC_SANITIZE  = 8'hB4;
  localparam logic [15:0] FEAT_STATUS   = 16'h0000;
  localparam logic [15:0] FEAT_OVERWR   = 16'h0014;
  localparam logic [15:0] FEAT_FREEZE   = 16'h0020;
  localparam logic [31:0] FREEZE_KEY    = 32'h46724C6B;
  localparam int          FAIL_MODE_BIT = 4;
  localparam int          CLR_FAIL_BIT  = 0;

  // answer fields
  localparam int          CNT_OK_BIT    = 15;
  localparam int          CNT_ACT_BIT   = 14;
  localparam int          CNT_FRZ_BIT   = 13;
  localparam int          ST_RDY_BIT    = 6;
  localparam int          ST_DSC_BIT    = 4;
  localparam int          ST_ERR_BIT    = 0;
  localparam int          ER_ABT_BIT    = 2;
  localparam logic [15:0] PROG_NONE     = 16'hFFFF;

  // error reason codes
  localparam logic [7:0]  RSN_NONE      = 8'h00;
  localparam logic [7:0]  RSN_UNSAN     = 8'h01;
  localparam logic [7:0]  RSN_BADFEAT   = 8'h02;
  localparam logic [7:0]  RSN_FROZEN    = 8'h03;

  // register byte addresses
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATE     = 8'h04;
  localparam logic [7:0]  REG_PROG      = 8'h08;
  localparam logic [7:0]  REG_IRQ_ST    = 8'h0C;
  localparam logic [7:0]  REG_IRQ_MSK   = 8'h10;
  localparam int          CTRL_HWRST    = 0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // interrupt event bits
  localparam int          EV_DONE       = 0;
  localparam int          EV_ABORT      = 1;
  localparam int          EV_OPEND      = 2;
  localparam int          EV_FROZEN     = 3;
  localparam int          EV_W          = 4;

  typedef enum logic [4:0] {
    SAN_IDLE   = 5'h01,
    SAN_FROZEN = 5'h02,
    SAN_ACTIVE = 5'h04,
    SAN_FAILED = 5'h08,
    SAN_OK     = 5'h10
  } san_state_e;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [15:0] feature;
    logic [15:0] count;
    logic [47:0] lba;
  } taskfile_s;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  error;
    logic [15:0] count;
    logic [7:0]  sect_num;
    logic [7:0]  cyl_low;
  } answer_s;

endpackage
